/* File: tpg_consts.vh */
// Purpose: constants for the test pattern and tile gain block
// Assumes: 8-bit register index, 16-bit register data
// Notes: register index equals byte offset on the serial port
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH
`define TPG_REG_TEST 8'h7F
`define TPG_REG_TILE_FIRST 8'h80
`define TPG_REG_TILE_LAST 8'h98
`define TPG_REG_COL0 8'h99
`define TPG_REG_COL3 8'h9C
`define TPG_REG_ROW0 8'h9F
`define TPG_REG_ROW3 8'hA2
`define TPG_TILE_RESET 8'hF4
`define TPG_COL0_RESET 10'h000
`define TPG_COL1_RESET 10'h096
`define TPG_COL2_RESET 10'h12C
`define TPG_COL3_RESET 10'h1C2
`define TPG_ROW0_RESET 9'h000
`define TPG_ROW1_RESET 9'h060
`define TPG_ROW2_RESET 9'h0C0
`define TPG_ROW3_RESET 9'h120
`define TPG_BIT_SOURCE 10
`define TPG_BIT_ENABLE 13
`define TPG_BIT_FLIP 14
`define TPG_PAT_LSB 11
`define TPG_PAT_NONE 2'h0
`define TPG_PAT_VERT 2'h1
`define TPG_PAT_HORZ 2'h2
`define TPG_PAT_DIAG 2'h3
`define TPG_FIFO_DEPTH 8
`define TPG_FIFO_AW 3
`endif

/* File: tpg_fifo.v */
// Purpose: small valid/ready fifo for the pixel stream
// Assumes: depth is a power of two
// Notes: no bypass, one cycle latency
`timescale 1ns/1ps
module tpg_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ***********************************
  // storage and pointers
  // ***********************************
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // entries
  reg [AW:0] wr_q; // extra bit tells full from empty
  reg [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];
  // data array, no reset needed
  always @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // tpg_fifo

/* File: tpg_top.v */
// Purpose: test data injection and tile_gain_weight_0 at chain start
// Assumes: pixel stream with column and row coordinates, one clock
// Notes: registers written and read on a simple indexed port
`timescale 1ns/1ps
`include "tpg_consts.vh"
module tpg_top (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  input wire [7:0] reg_addr, // register index
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata, // read data, valid cycle after reg_rd
  output reg reg_ack, // one-cycle acknowledge
  input wire adc_valid, // converter pixel strobe
  output wire adc_ready, // fifo has room
  input wire [9:0] adc_data,
  input wire [9:0] adc_col,
  input wire [8:0] adc_row,
  output reg pix_valid, // gained pixel out
  input wire pix_ready,
  output reg [11:0] pix_data, // data times gain in quarter steps, fits 12 bits without saturation
  output reg [7:0] pix_weight // weight of enclosing tile
);
  // ***********************************
  // control registers
  // ***********************************
  reg [15:0] test_q; // test control word
  reg [7:0] tile_q [0:24]; // gain and weight per tile
  reg [9:0] col_q [0:3]; // column starts
  reg [8:0] row_q [0:3]; // row starts, own mapping
  wire wr_test = reg_wr && (reg_addr == `TPG_REG_TEST);
  wire in_tile = (reg_addr >= `TPG_REG_TILE_FIRST) && (reg_addr <= `TPG_REG_TILE_LAST);
  wire in_col = (reg_addr >= `TPG_REG_COL0) && (reg_addr <= `TPG_REG_COL3);
  wire in_row = (reg_addr >= `TPG_REG_ROW0) && (reg_addr <= `TPG_REG_ROW3);
  wire [7:0] tile_off = reg_addr - `TPG_REG_TILE_FIRST;
  wire [7:0] col_off = reg_addr - `TPG_REG_COL0;
  wire [7:0] row_off = reg_addr - `TPG_REG_ROW0;
  // test control word, reserved bit 15 reads zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_q <= 16'h0000;
    end else if (wr_test) begin
      test_q <= {1'b0, reg_wdata[14:0]};
    end
  end
  // one register per tile, reset to unity gain and full weight
  genvar gi;
  generate
    for (gi = 0; gi < 25; gi = gi + 1) begin : g_tile
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          tile_q[gi] <= `TPG_TILE_RESET;
        end else if (reg_wr && in_tile && (tile_off == gi)) begin
          tile_q[gi] <= reg_wdata[7:0];
        end
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bound
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          case (gi)
            0: begin col_q[gi] <= `TPG_COL0_RESET; row_q[gi] <= `TPG_ROW0_RESET; end
            1: begin col_q[gi] <= `TPG_COL1_RESET; row_q[gi] <= `TPG_ROW1_RESET; end
            2: begin col_q[gi] <= `TPG_COL2_RESET; row_q[gi] <= `TPG_ROW2_RESET; end
            default: begin col_q[gi] <= `TPG_COL3_RESET; row_q[gi] <= `TPG_ROW3_RESET; end
          endcase
        end else begin
          if (reg_wr && in_col && (col_off == gi)) begin
            col_q[gi] <= reg_wdata[9:0];
          end
          if (reg_wr && in_row && (row_off == gi)) begin
            row_q[gi] <= reg_wdata[8:0];
          end
        end
      end
    end
  endgenerate
  // read back; unmapped indices answer zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_rd || reg_wr;
      if (reg_rd) begin
        if (reg_addr == `TPG_REG_TEST) begin
          reg_rdata <= test_q;
        end else if (in_tile) begin
          reg_rdata <= {8'h00, tile_q[tile_off[4:0]]};
        end else if (in_col) begin
          reg_rdata <= {6'h00, col_q[col_off[1:0]]};
        end else if (in_row) begin
          reg_rdata <= {7'h00, row_q[row_off[1:0]]};
        end else begin
          reg_rdata <= 16'h0000;
        end
      end
    end
  end
  // ***********************************
  // test data selection
  // ***********************************
  wire tst_en = test_q[`TPG_BIT_ENABLE];
  wire tst_src = test_q[`TPG_BIT_SOURCE];
  wire tst_flip = test_q[`TPG_BIT_FLIP];
  wire [1:0] tst_pat = test_q[`TPG_PAT_LSB+1:`TPG_PAT_LSB];
  wire [9:0] tst_const = test_q[9:0];
  wire [10:0] diag_sum = {1'b0, adc_col} + {2'b00, adc_row};
  reg [9:0] inj_data; // data entering the chain
  // software is expected to have row noise correction off here
  always @* begin
    inj_data = adc_data;
    if (tst_en) begin
      if (tst_src) begin
        // flip meaningful only with constant source
        if (tst_flip && !adc_col[0]) begin
          inj_data = ~tst_const;
        end else begin
          inj_data = tst_const;
        end
      end else begin
        case (tst_pat)
          `TPG_PAT_VERT: inj_data = adc_col;
          `TPG_PAT_HORZ: inj_data = {1'b0, adc_row};
          `TPG_PAT_DIAG: inj_data = diag_sum[9:0];
          default: inj_data = adc_data;
        endcase
      end
    end
  end
  // ***********************************
  // stream buffer, injection first
  // ***********************************
  wire f_valid;
  wire f_ready;
  wire [28:0] f_data;
  tpg_fifo #(
    .WIDTH(29),
    .DEPTH(`TPG_FIFO_DEPTH),
    .AW(`TPG_FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data({adc_row, adc_col, inj_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  wire [9:0] q_data = f_data[9:0];
  wire [9:0] q_col = f_data[19:10];
  wire [8:0] q_row = f_data[28:20];
  // ***********************************
  // tile lookup and gain
  // ***********************************
  reg [2:0] tx; // tile column index
  reg [2:0] ty; // tile row index
  integer k;
  // last boundary not above the coordinate wins
  always @* begin
    tx = 3'h0;
    ty = 3'h0;
    for (k = 1; k < 4; k = k + 1) begin
      if (q_col >= col_q[k]) begin
        tx = k[2:0];
      end
      if (q_row >= row_q[k]) begin
        ty = k[2:0];
      end
    end
    // fifth tile column and row start at fixed coordinates 600 and 384
    if (q_col >= 10'h258) begin
      tx = 3'h4;
    end
    if (q_row >= 9'h180) begin
      ty = 3'h4;
    end
  end
  wire [4:0] tidx = {2'b00, ty} * 5'h05 + {2'b00, tx};
  wire [7:0] tsel = tile_q[tidx];
  wire [13:0] prod = q_data * tsel[3:0]; // gain in quarter steps
  // largest product 1023 x 15 fits 14 bits, so the quarter step never overflows 12 bits
  wire [11:0] scaled = prod[13:2];
  assign f_ready = !pix_valid || pix_ready; // output stall backs up fifo
  // registered output stage
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pix_valid <= 1'b0;
      pix_data <= 12'h000;
      pix_weight <= 8'h00;
    end else if (f_ready) begin
      pix_valid <= f_valid;
      if (f_valid) begin
        pix_data <= scaled;
        pix_weight <= {4'h0, tsel[7:4]};
      end
    end
  end
endmodule // tpg_top

/* File: tpg_top_assertions.sv */
// Purpose: port checks for tpg_top
// Assumes: one clock, async high reset
// Notes: bound to tpg_top at the foot
`timescale 1ns/1ps
module tpg_chk (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_rdata,
  input wire reg_ack,
  input wire pix_valid,
  input wire pix_ready,
  input wire [11:0] pix_data,
  input wire [7:0] pix_weight
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_no_ack; !(reg_wr || reg_rd) |=> !reg_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_unmap; reg_rd && (reg_addr < 8'h7F || reg_addr > 8'hA2) |=> reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_test_w; reg_rd && reg_addr == 8'h7F |=> !reg_rdata[15]; endproperty
  a_test_w: assert property (p_test_w) else $error("test reg top bit set");
  property p_tile_w; reg_rd && reg_addr >= 8'h80 && reg_addr <= 8'h98 |=> reg_rdata[15:8] == 8'h00; endproperty
  a_tile_w: assert property (p_tile_w) else $error("tile reg too wide");
  property p_col_w; reg_rd && reg_addr >= 8'h99 && reg_addr <= 8'h9C |=> reg_rdata[15:10] == 6'h00; endproperty
  a_col_w: assert property (p_col_w) else $error("column start too wide");
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_hold; pix_valid && !pix_ready |=> pix_valid && $stable(pix_data) && $stable(pix_weight); endproperty
  a_hold: assert property (p_hold) else $error("pixel dropped in stall");
  property p_wt; pix_valid |-> pix_weight[7:4] == 4'h0; endproperty
  a_wt: assert property (p_wt) else $error("weight upper bits set");
endmodule // tpg_chk
bind tpg_top tpg_chk tpg_chk_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .pix_data(pix_data), .pix_weight(pix_weight));

/* File: tb_test_pattern_and_tile_gain.sv */
// Purpose: self-checking bench for tpg_top
// Assumes: default tile grid, inputs driven at falling edge
// Notes: expected pixels queued at accept, popped at output
`timescale 1ns/1ps
module tb_test_pattern_and_tile_gain;
  reg sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, adc_valid = 0, pix_ready = 1, stall = 0;
  reg [7:0] reg_addr = 8'h00, i;
  reg [15:0] reg_wdata = 16'h0000, ctl = 16'h0000;
  reg [9:0] adc_data = 10'h000, adc_col = 10'h000;
  reg [8:0] adc_row = 9'h000;
  wire [15:0] reg_rdata;
  wire reg_ack, adc_ready, pix_valid;
  wire [11:0] pix_data;
  wire [7:0] pix_weight;
  integer fails = 0, n_tests = 0, cyc = 0, k, j, m;
  reg [31:0] seed = 32'h15D9;
  reg [7:0] tg [0:24]; // model of tile registers
  reg [15:0] q [$]; // pixels in flight
  // modes as bits 14:10 of the test register; flip only with constant source
  // row noise correction lives outside this block, so it is never on here
  localparam [49:0] MODES = {5'b00000, 5'b00001, 5'b01001, 5'b11001, 5'b01010,
    5'b01100, 5'b01110, 5'b01000, 5'b00110, 5'b01111};
  tpg_top tpg_top_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_data(adc_data), .adc_col(adc_col), .adc_row(adc_row),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_weight(pix_weight));
  initial forever #5 sys_clk = ~sys_clk;
  task nx; begin seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5); end endtask
  // expected {weight, data}; product never reaches saturation
  function [15:0] exp_px(input [9:0] d, input [9:0] c, input [8:0] r);
    reg [9:0] t;
    reg [7:0] g;
    reg [13:0] p;
    integer x, y;
    begin
      t = d;
      if (ctl[13] && ctl[10]) t = (ctl[14] && !c[0]) ? ~ctl[9:0] : ctl[9:0];
      else if (ctl[13] && ctl[12:11] != 2'h0) t = ctl[12:11] == 2'h1 ? c : ctl[12:11] == 2'h2 ? {1'b0, r} : c + r;
      x = (c >= 600) + (c >= 450) + (c >= 300) + (c >= 150);
      y = (r >= 384) + (r >= 288) + (r >= 192) + (r >= 96);
      g = tg[y * 5 + x];
      p = t * g[3:0];
      exp_px = {g[7:4], p[13:2]};
    end
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin @(negedge sys_clk); reg_wr = 1; reg_addr = a; reg_wdata = d; @(negedge sys_clk); reg_wr = 0; end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      @(negedge sys_clk); reg_rd = 1; reg_addr = a; @(negedge sys_clk); reg_rd = 0;
      chk("rdata", e, reg_rdata);
      chk("ack", 16'h0001, {15'h0000, reg_ack});
    end
  endtask
  task px(input [9:0] c, input [8:0] r);
    begin
      nx;
      @(negedge sys_clk); adc_valid = 1; adc_data = seed[9:0]; adc_col = c; adc_row = r;
      k = 0;
      while (adc_ready !== 1'b1 && k < 50) begin @(negedge sys_clk); k = k + 1; end
      @(posedge sys_clk); q.push_back(exp_px(adc_data, c, r));
      @(negedge sys_clk); adc_valid = 0;
    end
  endtask
  task drain; begin k = 0; while (q.size() != 0 && k < 200) begin @(negedge sys_clk); k = k + 1; end end endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ****
  // output monitor, stall pattern, hang limit
  // ****
  always @(negedge sys_clk) if (stall) pix_ready = cyc[0] | cyc[2];
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin fails = fails + 1; stop_test; end
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      if (q.size() == 0) chk("extra pixel", 16'h0000, 16'hFFFF);
      else chk("pixel", q.pop_front(), {pix_weight[3:0], pix_data});
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk); rst = 0;
    for (i = 0; i < 25; i = i + 1) rd(8'h80 + i, 16'h00F4);
    rd(8'h99, 16'h0000); rd(8'h9A, 16'h0096); rd(8'h9B, 16'h012C); rd(8'h9C, 16'h01C2);
    rd(8'h7F, 16'h0000); rd(8'h7E, 16'h0000);
    wr(8'h99, 16'h02F0); rd(8'h99, 16'h02F0); wr(8'h99, 16'h0000);
    wr(8'h7F, 16'hFFFF); rd(8'h7F, 16'h7FFF);
    $display("done: register defaults");
    for (i = 0; i < 25; i = i + 1) begin
      nx;
      tg[i] = {seed[7:4], seed[3:0] == 4'h0 ? 4'h1 : seed[3:0]};
      if (i == 0) tg[i] = 8'h0F;
      if (i == 24) tg[i] = 8'hF1;
      wr(8'h80 + i, {8'h00, tg[i]});
    end
    rd(8'h98, 16'h00F1);
    stall = 1;
    for (m = 0; m < 10; m = m + 1) begin
      nx;
      ctl = {1'b0, MODES[m * 5 +: 5], seed[9:0]};
      drain;
      wr(8'h7F, ctl);
      px(10'h000, 9'h000); px(10'h095, 9'h05F); px(10'h096, 9'h060); px(10'h2EF, 9'h1DF);
      for (j = 0; j < 8; j = j + 1) begin nx; px(10'(seed[9:0] % 752), 9'(seed[24:16] % 480)); end
      drain;
      $display("done: mode %0d", m);
    end
    stall = 0;
    @(negedge sys_clk); pix_ready = 0;
    for (j = 0; adc_ready === 1'b1 && j < 20; j = j + 1) px(10'h1C2, 9'h180);
    chk("fill", 16'h0001, {15'h0000, j >= 8 && adc_ready === 1'b0});
    @(negedge sys_clk); pix_ready = 1;
    drain;
    chk("left", 16'h0000, q.size());
    $display("done: fill and drain");
    stop_test;
  end
endmodule // tb_test_pattern_and_tile_gain
